// ===== logic/adjust_pkg.sv
package adjust_pkg;
  // Frame codes
  localparam logic [7:0] ADJ_CMD_CODE = 8'h3e;
  localparam logic [7:0] ADJ_BYTE2 = 8'h00;
  localparam logic [7:0] SUB_DATA_SET = 8'h01;
  // Addresses and values
  localparam logic [15:0] ADDR_MODE = 16'h2000;
  localparam logic [15:0] ADDR_ACTION = 16'h2001;
  localparam logic [15:0] ADDR_PANEL = 16'h2002;
  localparam logic [15:0] VAL_MULTITURN = 16'h1013;
  localparam logic [15:0] VAL_OFFSET = 16'h100e;
  localparam logic [15:0] VAL_EXECUTE = 16'h0001;
  localparam logic [15:0] VAL_SAVE = 16'h0002;
  // Answer codes
  localparam logic [7:0] ANS_OK = 8'h01;
  localparam logic [7:0] ANS_REFUSED = 8'h00;
  // Timing
  localparam int CLK_HZ = 10000000;
  localparam int EXEC_TIME_MS = 2000;
  localparam int EXEC_CYCLES = CLK_HZ / 1000 * EXEC_TIME_MS;
  // Mode enumeration
  typedef enum logic [1:0] {
    MODE_NONE,
    MODE_MULTITURN,
    MODE_OFFSET
  } adj_mode_t;
endpackage : adjust_pkg

// ===== logic/adjust_command_sequencer.sv
`timescale 1ns/1ns
module adjust_command_sequencer #(
  parameter int EXEC_CYCLES = adjust_pkg::EXEC_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Command frame
  input wire logic frame_valid_i,
  input wire logic [7:0] frame_code_i,
  input wire logic [7:0] frame_byte2_i,
  input wire logic [7:0] sub_command_code_i,
  input wire logic [15:0] setting_address_field_i,
  input wire logic [15:0] setting_value_field_i,
  // Drive conditions (pins)
  input wire logic servo_on_i,
  input wire logic main_power_i,
  input wire logic handheld_attached_i,
  input wire logic pc_comm_active_i,
  input wire logic panel_off_req_i,
  // Response
  output logic [7:0] sub_command_answer_o,
  output logic [15:0] setting_address_field_o,
  output logic [15:0] setting_value_field_o,
  output logic response_valid_o,
  output logic command_ready_flag_o,
  // Adjustment control
  output logic [1:0] mode_o,
  output logic save_pulse_o,
  output logic exec_busy_o,
  output logic panel_enable_o
);

  // Refuse a run length the down counter cannot serve
  if (EXEC_CYCLES < 2) begin : gen_exec_check
    $error("EXEC_CYCLES too small");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, one per drive condition pin

  logic [4:0] pin_raw;
  logic [4:0] pin_lvl;
  logic servo_on_s;
  logic main_power_s;
  logic handheld_s;
  logic pc_comm_s;
  logic panel_off_s;

  assign pin_raw = {panel_off_req_i, pc_comm_active_i, handheld_attached_i, main_power_i,
                    servo_on_i};

  for (genvar g = 0; g < 5; g++) begin : gen_pin_sync
    pin_sync pin_sync_i (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .pin_i(pin_raw[g]),
      .level_o(pin_lvl[g])
    );
  end

  assign {panel_off_s, pc_comm_s, handheld_s, main_power_s, servo_on_s} = pin_lvl;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state

  typedef struct packed {
    adjust_pkg::adj_mode_t mode;
    logic busy;
    logic [31:0] cnt;
    logic ready;
    logic resp_valid;
    logic [7:0] answer;
    logic [15:0] addr;
    logic [15:0] data;
    logic save;
    logic panel_en;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode

  logic is_adj;
  logic is_set;
  logic wr_mode;
  logic wr_act;
  logic wr_panel;
  logic offset_ok;
  logic panel_ok;

  assign is_adj = frame_valid_i && frame_code_i == adjust_pkg::ADJ_CMD_CODE
                  && frame_byte2_i == adjust_pkg::ADJ_BYTE2;
  assign is_set = is_adj && sub_command_code_i == adjust_pkg::SUB_DATA_SET;
  assign wr_mode = is_set && setting_address_field_i == adjust_pkg::ADDR_MODE;
  assign wr_act = is_set && setting_address_field_i == adjust_pkg::ADDR_ACTION;
  assign wr_panel = is_set && setting_address_field_i == adjust_pkg::ADDR_PANEL;
  assign offset_ok = !servo_on_s && main_power_s;
  assign panel_ok = !handheld_s && !pc_comm_s;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    logic ok;
    ok = 1'b0;
    st_nxt = st_r;
    st_nxt.resp_valid = 1'b0;
    st_nxt.save = 1'b0;
    // Synchronised panel-off pin may blank the indicator
    if (panel_off_s) begin
      st_nxt.panel_en = 1'b0;
    end
    if (st_r.busy) begin
      // New frames ignored while execution runs
      if (st_r.cnt == 32'h0000_0001) begin
        st_nxt.busy = 1'b0;
        st_nxt.ready = 1'b1;
        st_nxt.resp_valid = 1'b1;
        st_nxt.mode = adjust_pkg::MODE_NONE;
      end
      st_nxt.cnt = st_r.cnt - 32'h0000_0001;
    end else if (is_adj) begin
      st_nxt.addr = setting_address_field_i;
      st_nxt.data = setting_value_field_i;
      st_nxt.ready = 1'b0;
      if (wr_mode && setting_value_field_i == adjust_pkg::VAL_MULTITURN) begin
        st_nxt.mode = adjust_pkg::MODE_MULTITURN;
        ok = 1'b1;
      end else if (wr_mode && setting_value_field_i == adjust_pkg::VAL_OFFSET) begin
        st_nxt.mode = adjust_pkg::MODE_OFFSET;
        ok = 1'b1;
      end else if (wr_act && setting_value_field_i == adjust_pkg::VAL_SAVE
                   && st_r.mode != adjust_pkg::MODE_NONE) begin
        st_nxt.save = 1'b1;
        ok = 1'b1;
      end else if (wr_act && setting_value_field_i == adjust_pkg::VAL_EXECUTE
                   && (st_r.mode == adjust_pkg::MODE_MULTITURN
                       || (st_r.mode == adjust_pkg::MODE_OFFSET && offset_ok))) begin
        st_nxt.busy = 1'b1;
        st_nxt.cnt = 32'(EXEC_CYCLES);
        ok = 1'b1;
      end else if (wr_panel) begin
        if (panel_ok) begin
          st_nxt.panel_en = 1'b1;
        end
        ok = panel_ok;
      end
      if (!st_nxt.busy) begin
        st_nxt.answer = ok ? adjust_pkg::ANS_OK : adjust_pkg::ANS_REFUSED;
        st_nxt.ready = 1'b1;
        st_nxt.resp_valid = 1'b1;
      end else begin
        st_nxt.answer = adjust_pkg::ANS_OK;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_r <= '{mode: adjust_pkg::MODE_NONE, ready: 1'b1, panel_en: 1'b1, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sub_command_answer_o = st_r.answer;
  assign setting_address_field_o = st_r.addr;
  assign setting_value_field_o = st_r.data;
  assign response_valid_o = st_r.resp_valid;
  assign command_ready_flag_o = st_r.ready;
  assign mode_o = st_r.mode;
  assign save_pulse_o = st_r.save;
  assign exec_busy_o = st_r.busy;
  assign panel_enable_o = st_r.panel_en;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_ready_low_busy: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    exec_busy_o |-> !command_ready_flag_o)
    else $error("ready high during execution");

  chk_mode_multi: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!exec_busy_o && wr_mode && setting_value_field_i == adjust_pkg::VAL_MULTITURN)
    |=> mode_o == adjust_pkg::MODE_MULTITURN)
    else $error("multiturn mode not entered");

  chk_mode_offset: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!exec_busy_o && wr_mode && setting_value_field_i == adjust_pkg::VAL_OFFSET)
    |=> mode_o == adjust_pkg::MODE_OFFSET)
    else $error("offset mode not entered");

  chk_save_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    save_pulse_o |-> $past(wr_act) && $past(mode_o) != adjust_pkg::MODE_NONE
      && $past(setting_value_field_i) == adjust_pkg::VAL_SAVE)
    else $error("save pulse without request");

  chk_exec_start: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(exec_busy_o) |-> $past(wr_act)
      && $past(setting_value_field_i) == adjust_pkg::VAL_EXECUTE)
    else $error("execution without request");

  chk_ack_ready: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!exec_busy_o && is_adj && !(wr_act
      && setting_value_field_i == adjust_pkg::VAL_EXECUTE))
    |=> response_valid_o && command_ready_flag_o)
    else $error("no answer to command");

  chk_offset_cond: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ($rose(exec_busy_o) && mode_o == adjust_pkg::MODE_OFFSET)
    |-> $past(offset_ok))
    else $error("offset run with servo on or no power");

  chk_panel_cond: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(panel_enable_o) |-> $past(wr_panel) && $past(panel_ok))
    else $error("panel enabled illegally");

  chk_exec_end: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(exec_busy_o) |-> command_ready_flag_o && response_valid_o)
    else $error("execution end without ready");

  chk_frame_ignore: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!exec_busy_o && !is_adj) |=> !response_valid_o)
    else $error("answer to a frame that is not an adjusting command");

  chk_sub_refuse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (!exec_busy_o && is_adj && !is_set)
    |=> sub_command_answer_o == adjust_pkg::ANS_REFUSED)
    else $error("unknown sub-command accepted");

  chk_busy_drop: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (exec_busy_o && frame_valid_i)
    |=> $stable(setting_address_field_o) && $stable(setting_value_field_o))
    else $error("frame taken during execution");

  chk_panel_blank: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (panel_off_s && !(wr_panel && panel_ok && !exec_busy_o)) |=> !panel_enable_o)
    else $error("indicator lit while blanked");

  chk_save_answer: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    save_pulse_o |-> response_valid_o && sub_command_answer_o == adjust_pkg::ANS_OK)
    else $error("save pulse without accepted answer");

  cov_exec: cover property (@(posedge clk_i) $fell(exec_busy_o));
  cov_save: cover property (@(posedge clk_i) save_pulse_o);
  cov_panel: cover property (@(posedge clk_i) $rose(panel_enable_o));
  cov_offset_run: cover property (@(posedge clk_i)
    $rose(exec_busy_o) && mode_o == adjust_pkg::MODE_OFFSET);
  cov_refused: cover property (@(posedge clk_i)
    response_valid_o && sub_command_answer_o == adjust_pkg::ANS_REFUSED);

endmodule : adjust_command_sequencer

////////////////////////////////////////////////////////////////////////////////
// Three-stage pin synchroniser; level moves only when stages two and three agree

module pin_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Pin and filtered level
  input wire logic pin_i,
  output logic level_o
);

  typedef struct packed {
    logic [2:0] stage;
    logic level;
  } sync_t;

  sync_t st_r;
  sync_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.stage = {st_r.stage[1:0], pin_i};
    // Stage zero may be metastable, so only the later two are compared
    if (st_r.stage[1] == st_r.stage[2]) begin
      st_nxt.level = st_r.stage[2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_o = st_r.level;

endmodule : pin_sync

// ===== sim/host_model.sv
`timescale 1ns/1ns
module host_model (
  // Clock and answer
  input wire logic clk_i,
  input wire logic response_valid_i,
  // Command frame
  output logic frame_valid_o,
  output logic [7:0] frame_code_o,
  output logic [7:0] frame_byte2_o,
  output logic [7:0] sub_code_o,
  output logic [15:0] addr_o,
  output logic [15:0] value_o
);
  initial begin
    frame_valid_o = 1'b0;
    {frame_code_o, frame_byte2_o, sub_code_o, addr_o, value_o} = 56'h0;
  end
  // One frame, then wait up to wait_n cycles for the answer before the next step
  task send(input logic [7:0] code, input logic [7:0] b2, input logic [7:0] sub,
    input logic [15:0] addr, input logic [15:0] val, input int wait_n);
    int n;
    @(negedge clk_i);
    frame_valid_o = 1'b1;
    {frame_code_o, frame_byte2_o, sub_code_o, addr_o, value_o} = {code, b2, sub, addr, val};
    @(negedge clk_i);
    frame_valid_o = 1'b0;
    // Released fields carry garbage so stale values cannot pass
    {frame_code_o, frame_byte2_o, sub_code_o, addr_o, value_o} = ~{code, b2, sub, addr, val};
    for (n = 0; n < wait_n && response_valid_i !== 1'b1; n++) @(negedge clk_i);
  endtask : send
endmodule : host_model

// ===== sim/testbench.sv
`timescale 1ns/1ns
module testbench;
  typedef struct {
    logic [7:0] ans;
    logic [1:0] mode;
    logic pan;
    int busy;
    logic [15:0] a;
    logic [15:0] d;
    logic sv;
  } note_t;
  localparam int EXEC = 10;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic servo_i = 1'b0, power_i = 1'b1, hand_i = 1'b0, pc_i = 1'b0, off_i = 1'b0;
  logic fv;
  logic [7:0] fc, fb, sc, ans;
  logic [15:0] fa, fd, ao, vo;
  logic rv, rdy, sp, busy, pan;
  logic [1:0] mode;
  int errors = 0, comparisons = 0, cycles = 0, busy_n = 0;
  logic [31:0] r;
  note_t notes[$];
  note_t n;
  initial forever #50 clk_i = ~clk_i;
  host_model host_model_i (.clk_i(clk_i), .response_valid_i(rv), .frame_valid_o(fv),
    .frame_code_o(fc), .frame_byte2_o(fb), .sub_code_o(sc), .addr_o(fa), .value_o(fd));
  adjust_command_sequencer #(.EXEC_CYCLES(EXEC)) adjust_command_sequencer_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .frame_valid_i(fv), .frame_code_i(fc),
    .frame_byte2_i(fb), .sub_command_code_i(sc), .setting_address_field_i(fa),
    .setting_value_field_i(fd), .servo_on_i(servo_i), .main_power_i(power_i),
    .handheld_attached_i(hand_i), .pc_comm_active_i(pc_i), .panel_off_req_i(off_i),
    .sub_command_answer_o(ans), .setting_address_field_o(ao), .setting_value_field_o(vo),
    .response_valid_o(rv), .command_ready_flag_o(rdy), .mode_o(mode), .save_pulse_o(sp),
    .exec_busy_o(busy), .panel_enable_o(pan));
  ////////////////////////////////////////////////////////////////////////////
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task report_and_stop();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  task cmd(input logic [7:0] sub, input logic [15:0] a, input logic [15:0] d, input int w,
    input logic [7:0] ans_e, input logic [1:0] mode_e, input logic pan_e, input int busy_e);
    // An accepted save answer carries a save pulse with it
    notes.push_back('{ans_e, mode_e, pan_e, busy_e, a, d,
                      ans_e == adjust_pkg::ANS_OK && a == adjust_pkg::ADDR_ACTION
                      && d == adjust_pkg::VAL_SAVE});
    host_model_i.send(adjust_pkg::ADJ_CMD_CODE, adjust_pkg::ADJ_BYTE2, sub, a, d, w);
  endtask : cmd
  task pins(input logic s, input logic p, input logic h, input logic c, input logic o);
    @(negedge clk_i);
    {servo_i, power_i, hand_i, pc_i, off_i} = {s, p, h, c, o};
    // Pins pass a synchroniser first
    repeat (5) @(negedge clk_i);
  endtask : pins
  ////////////////////////////////////////////////////////////////////////////
  // Monitor: every answer takes the oldest note
  always @(negedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      errors++;
      report_and_stop();
    end
    if (busy === 1'b1) begin
      busy_n = busy_n + 1;
      check("ready_busy", rdy, 1'b0);
    end
    if (rv !== 1'b1 && sp !== 1'b0) check("stray_save", sp, 1'b0);
    if (rv === 1'b1) begin
      if (notes.size() == 0) check("spurious", 1'b1, 1'b0);
      else begin
        n = notes.pop_front();
        check("answer", ans, n.ans);
        check("ready", rdy, 1'b1);
        check("echo", ao, n.a);
        check("mode", mode, n.mode);
        check("panel", pan, n.pan);
        check("busy_len", busy_n, n.busy);
        check("value_echo", vo, n.d);
        check("save", sp, n.sv);
      end
      busy_n = 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    r = $urandom(32'h0fbfad3c);
    repeat (8) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    check("reset_ready", rdy, 1'b1);
    check("reset_panel", pan, 1'b1);
    check("reset_mode", mode, 2'd0);
    r = $urandom;
    host_model_i.send(8'h3e ^ (r[7:0] | 8'h01), 8'h00, 8'h01, 16'h2000, 16'h1013, 4);
    host_model_i.send(8'h3e, r[15:8] | 8'h01, 8'h01, 16'h2000, 16'h1013, 4);
    cmd(r[23:16] | 8'h02, 16'h2000, 16'h1013, 4, 8'h00, 2'd0, 1'b1, 0);
    cmd(8'h01, 16'h2001, 16'h0002, 4, 8'h00, 2'd0, 1'b1, 0);
    // Multiturn: select, save, execute; a frame while busy is dropped
    cmd(8'h01, 16'h2000, 16'h1013, 4, 8'h01, 2'd1, 1'b1, 0);
    cmd(8'h01, 16'h2001, 16'h0002, 4, 8'h01, 2'd1, 1'b1, 0);
    cmd(8'h01, 16'h2001, 16'h0001, 0, 8'h01, 2'd0, 1'b1, EXEC);
    host_model_i.send(8'h3e, 8'h00, 8'h01, 16'h2000, 16'h100e, EXEC + 4);
    // Offset runs only with servo off and power on
    pins(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    cmd(8'h01, 16'h2000, 16'h100e, 4, 8'h01, 2'd2, 1'b1, 0);
    cmd(8'h01, 16'h2001, 16'h0001, 4, 8'h00, 2'd2, 1'b1, 0);
    pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    cmd(8'h01, 16'h2001, 16'h0001, 4, 8'h00, 2'd2, 1'b1, 0);
    pins(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    cmd(8'h01, 16'h2001, 16'h0001, EXEC + 4, 8'h01, 2'd0, 1'b1, EXEC);
    // Panel write refused with a handheld unit or PC link, else re-enables
    pins(1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
    cmd(8'h01, 16'h2002, r[31:16], 4, 8'h00, 2'd0, 1'b0, 0);
    pins(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    cmd(8'h01, 16'h2002, r[15:0], 4, 8'h00, 2'd0, 1'b0, 0);
    pins(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    cmd(8'h01, 16'h2002, r[31:16], 4, 8'h01, 2'd0, 1'b1, 0);
    repeat (5) @(negedge clk_i);
    check("notes_left", notes.size(), 0);
    report_and_stop();
  end
endmodule : testbench
